// ### src/usb_ep_pkg.sv
// shared constants for the endpoint fifo data path
package usb_ep_pkg;
	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_EP = 4;
	localparam int PTR_W = 6;
	localparam int MAX_PKT = 64;
	localparam int NUM_DMA_CH = 6;
	// channels below this index are receive channels, the rest transmit
	localparam int DMA_RX_CH = 3;

	// ----------------------------------------------------------------
	// transaction types carried by a transmit trigger
	// ----------------------------------------------------------------
	localparam logic [2:0] trans_type_host_out = 3'h0;
	localparam logic [2:0] trans_type_device_in = 3'h1;
	localparam logic [2:0] trans_type_final_in_ep0 = 3'h2;
	localparam logic [2:0] trans_type_setup_ep0 = 3'h3;
	localparam logic [2:0] trans_type_status_ep0 = 3'h4;

	// ----------------------------------------------------------------
	// direction selects; any other code is ignored
	// ----------------------------------------------------------------
	localparam logic [2:0] dir_device_in = 3'h1;
	localparam logic [2:0] dir_device_out = 3'h2;
	localparam logic [2:0] dir_host_in = 3'h3;
	localparam logic [2:0] dir_host_out = 3'h4;

	// ----------------------------------------------------------------
	// status flag positions (receive half low byte, transmit half high)
	// ----------------------------------------------------------------
	localparam int F_PKT_READY = 0;
	localparam int F_RX_FULL = 1;
	localparam int F_DATA_ERR = 2;
	localparam int F_STALL_RX = 3;
	localparam int F_NO_RESP_RX = 4;
	localparam int F_PID_ERR = 5;
	localparam int F_EARLY_END = 5;
	localparam int F_NAK_TO_RX = 6;
	localparam int F_ERROR_RX = 7;
	localparam int F_OVERRUN = 7;
	localparam int F_TX_PEND = 8;
	localparam int F_TX_NOT_EMPTY = 9;
	localparam int F_UNDERRUN = 14;
	localparam logic [15:0] STICKY_MASK = 16'hFCFC;
	localparam logic [15:0] HOST_MASK = 16'h3FFF;
	localparam logic [15:0] DEV_MASK = 16'hC78F;
	localparam logic [15:0] HOST_EP0_MASK = 16'h0059;
	localparam logic [15:0] DEV_EP0_MASK = 16'h0129;

	// ----------------------------------------------------------------
	// physical fifo access window, base and stride are arbitrary
	// ----------------------------------------------------------------
	localparam logic [31:0] FIFO_ADDR_BASE = 32'h0000_0020;
	localparam logic [31:0] FIFO_ADDR_STRIDE = 32'h0000_0004;
endpackage

// ### src/ep_byte_ram.sv
// byte memory shared by all endpoints of one direction
`timescale 1ns/1ps
`default_nettype none
module ep_byte_ram #(
	parameter int AW = 8
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic wr_en_in,
	input wire logic [AW-1:0] wr_addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic [AW-1:0] rd_addr_in,
	output logic [7:0] rd_data_out
);
	logic [7:0] mem [2**AW];

	always_ff @(posedge clk_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_data_out <= 8'h00;
		end else begin
			rd_data_out <= mem[rd_addr_in];
		end
	end
endmodule
`default_nettype wire

// ### src/usb_endpoint_fifo_datapath.sv
// endpoint fifo data path: loads, reads, send triggers, toggles, dma and status
//
// Behaviour
// - a receive read reports bytes delivered; zero length reads succeed with count zero
// - a receive read fails only when no packet waits in the fifo
// - load refused, nothing stored, busy shown while a packet awaits transmission
// - without automatic transmit, sending starts only on an explicit trigger
// - each trigger carries a transaction type which is signalled on the bus
// - a trigger is refused with failure while transmission is still in progress
// - toggle clear resets selected direction toggle to zero; ignored for endpoint zero
// - three rx and three tx dma channels map to any non-zero endpoint
// - dma disable returns direction to processor mode; other direction codes ignored
// - dma enable acts on selected direction and latches its access mode
// - host in endpoints flag pid, no response, stall, data, nak, error, full, ready
// - host out endpoints flag nak, no response, stall, error, not empty, pending
// - host endpoint zero flags nak timeout, no response, in stall, in ready
// - device out endpoints flag stall, data error, overrun, full, packet ready
// - device in endpoints flag split, stall, underrun, not empty, pending
// - device endpoint zero flags early end, stall, in pending, out ready
// - flags other than ready, full, pending and not empty stay set until cleared with the read pattern
// - each endpoint has a fixed physical fifo access address
// - automatic transmit starts once a full packet sits in the fifo
// - automatic clear drops packet ready after readout, else software clears
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_fifo_datapath #(
	parameter int N_EP = usb_ep_pkg::NUM_EP,
	parameter int PTR_W = usb_ep_pkg::PTR_W,
	parameter int MAX_PKT = usb_ep_pkg::MAX_PKT
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic host_role_in,
	input wire logic [N_EP-1:0] auto_transmit_on_full_packet_in,
	input wire logic [N_EP-1:0] auto_clear_packet_ready_in,
	input wire logic rd_req_in,
	input wire logic [$clog2(N_EP)-1:0] rd_ep_in,
	output logic rd_valid_out,
	output logic [7:0] rd_data_out,
	output logic rd_done_out,
	output logic rd_ok_out,
	output logic [PTR_W:0] rd_count_out,
	input wire logic wr_valid_in,
	input wire logic [$clog2(N_EP)-1:0] wr_ep_in,
	input wire logic [7:0] wr_data_in,
	output logic wr_busy_out,
	input wire logic send_req_in,
	input wire logic [$clog2(N_EP)-1:0] send_ep_in,
	input wire logic [2:0] send_type_in,
	output logic send_ok_out,
	output logic send_fail_out,
	input wire logic tog_clr_in,
	input wire logic [$clog2(N_EP)-1:0] tog_ep_in,
	input wire logic [2:0] tog_dir_in,
	input wire logic dma_map_in,
	input wire logic [2:0] dma_map_ch_in,
	input wire logic [$clog2(N_EP)-1:0] dma_map_ep_in,
	output logic [usb_ep_pkg::NUM_DMA_CH*$clog2(N_EP)-1:0] dma_ch_ep_out,
	output logic [usb_ep_pkg::NUM_DMA_CH-1:0] dma_ch_valid_out,
	output logic [usb_ep_pkg::NUM_DMA_CH-1:0] dma_req_out,
	input wire logic dma_en_in,
	input wire logic dma_dis_in,
	input wire logic [$clog2(N_EP)-1:0] dma_ep_in,
	input wire logic [2:0] dma_dir_in,
	input wire logic dma_mode_in,
	output logic [N_EP-1:0] dma_rx_en_out,
	output logic [N_EP-1:0] dma_tx_en_out,
	output logic [N_EP-1:0] dma_rx_mode_out,
	output logic [N_EP-1:0] dma_tx_mode_out,
	output logic [N_EP-1:0] ep_irq_out,
	input wire logic [$clog2(N_EP)-1:0] status_ep_in,
	output logic [15:0] status_out,
	output logic [31:0] fifo_addr_out,
	input wire logic status_clr_in,
	input wire logic [15:0] status_clr_mask_in,
	input wire logic link_rx_valid_in,
	input wire logic [$clog2(N_EP)-1:0] link_rx_ep_in,
	input wire logic [7:0] link_rx_data_in,
	input wire logic link_rx_end_in,
	input wire logic link_rx_good_in,
	output logic link_rx_toggle_out,
	input wire logic [$clog2(N_EP)-1:0] link_tx_ep_in,
	input wire logic link_tx_rd_in,
	input wire logic link_in_token_in,
	input wire logic link_tx_done_in,
	input wire logic link_tx_ack_in,
	output logic [7:0] link_tx_data_out,
	output logic [PTR_W:0] link_tx_len_out,
	output logic [2:0] link_tx_type_out,
	output logic link_tx_toggle_out,
	output logic [N_EP-1:0] link_tx_pend_out,
	input wire logic [15:0] link_evt_in,
	input wire logic [$clog2(N_EP)-1:0] link_evt_ep_in
);
	localparam int EW = $clog2(N_EP);
	localparam int CH = usb_ep_pkg::NUM_DMA_CH;
	localparam logic [PTR_W:0] DEPTH = (PTR_W+1)'(2**PTR_W);
	localparam logic [PTR_W:0] PKT_LAST = (PTR_W+1)'(MAX_PKT-1);

	typedef enum logic {RD_IDLE, RD_RUN} rd_state_t;

	function automatic logic sel(input logic v, input logic [EW-1:0] a, input int e);
		sel = v && (a == EW'(e));
	endfunction

	function automatic logic dir_tx(input logic [2:0] d);
		dir_tx = (d == usb_ep_pkg::dir_device_in) || (d == usb_ep_pkg::dir_host_out);
	endfunction

	function automatic logic dir_rx(input logic [2:0] d);
		dir_rx = (d == usb_ep_pkg::dir_device_out) || (d == usb_ep_pkg::dir_host_in);
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [PTR_W:0] tx_cnt_r [N_EP];
	logic [PTR_W:0] tx_cnt_nxt [N_EP];
	logic [PTR_W:0] rx_len_r [N_EP];
	logic [PTR_W:0] rx_len_nxt [N_EP];
	logic [2:0] tx_type_r [N_EP];
	logic [2:0] tx_type_nxt [N_EP];
	logic [15:0] sticky_r [N_EP];
	logic [15:0] sticky_nxt [N_EP];
	logic [15:0] stat_w [N_EP];
	logic [N_EP-1:0] tx_pend_r, tx_pend_nxt, rx_rdy_r, rx_rdy_nxt;
	logic [N_EP-1:0] tog_tx_r, tog_tx_nxt, tog_rx_r, tog_rx_nxt;
	logic [N_EP-1:0] dma_rx_en_nxt, dma_tx_en_nxt, dma_rx_mode_nxt, dma_tx_mode_nxt;
	logic [EW-1:0] ch_ep_r [CH];
	logic [CH-1:0] ch_ok_r;
	logic [PTR_W:0] rx_wcnt_r, tx_rptr_r, rd_ptr_r, rd_len_r, val_cnt_r;
	logic [EW-1:0] rd_ep_r;
	rd_state_t rd_state_r;
	logic rd_autoclr_r;
	logic [7:0] rx_rd_data, tx_rd_data;

	// ----------------------------------------------------------------
	// shared decode
	// ----------------------------------------------------------------
	wire tx_we = wr_valid_in && !tx_pend_r[wr_ep_in] && (tx_cnt_r[wr_ep_in] < DEPTH);
	assign wr_busy_out = wr_valid_in && tx_pend_r[wr_ep_in];
	assign send_ok_out = send_req_in && !tx_pend_r[send_ep_in];
	assign send_fail_out = send_req_in && tx_pend_r[send_ep_in];
	// a packet arriving while the previous one is unread is dropped whole
	wire rx_we = link_rx_valid_in && !rx_rdy_r[link_rx_ep_in] && (rx_wcnt_r < DEPTH);
	wire tog_ok = tog_clr_in && (tog_ep_in != '0);
	wire rd_start = (rd_state_r == RD_IDLE) && rd_req_in;
	wire rd_issue = (rd_state_r == RD_RUN) && (rd_ptr_r < rd_len_r);
	wire rd_finish = (rd_state_r == RD_RUN) && (rd_ptr_r == rd_len_r);
	assign link_rx_toggle_out = tog_rx_r[link_rx_ep_in];
	assign link_tx_toggle_out = tog_tx_r[link_tx_ep_in];
	assign link_tx_type_out = tx_type_r[link_tx_ep_in];
	assign link_tx_len_out = tx_cnt_r[link_tx_ep_in];
	assign link_tx_pend_out = tx_pend_r;
	assign link_tx_data_out = tx_rd_data;
	assign rd_data_out = rx_rd_data;

	// ----------------------------------------------------------------
	// per endpoint logic
	// ----------------------------------------------------------------
	for (genvar e = 0; e < N_EP; e++) begin : g_ep
		wire wr_take = tx_we && (wr_ep_in == EW'(e));
		wire auto_go = auto_transmit_on_full_packet_in[e] && wr_take && (tx_cnt_r[e] == PKT_LAST);
		wire send_go = sel(send_ok_out, send_ep_in, e);
		wire done_hit = sel(link_tx_done_in && link_tx_ack_in, link_tx_ep_in, e);
		wire rx_end = sel(link_rx_end_in, link_rx_ep_in, e);
		wire rx_take = rx_end && link_rx_good_in && !rx_rdy_r[e];
		wire overrun = rx_end && rx_rdy_r[e] && !host_role_in;
		wire underrun = sel(link_in_token_in, link_tx_ep_in, e) && !tx_pend_r[e] && !host_role_in;
		wire clr_hit = sel(status_clr_in, status_ep_in, e);
		wire tog_hit = sel(tog_ok, tog_ep_in, e);
		wire dma_hit = sel(dma_en_in || dma_dis_in, dma_ep_in, e);
		wire [15:0] evt_set = sel(1'b1, link_evt_ep_in, e) ? (link_evt_in & usb_ep_pkg::STICKY_MASK) : 16'h0000;
		wire [15:0] own_set = (16'(overrun) << usb_ep_pkg::F_OVERRUN) | (16'(underrun) << usb_ep_pkg::F_UNDERRUN);
		wire [15:0] live = (16'(rx_rdy_r[e]) << usb_ep_pkg::F_PKT_READY)
			| (16'(rx_rdy_r[e] && rx_len_r[e] == DEPTH) << usb_ep_pkg::F_RX_FULL)
			| (16'(tx_pend_r[e]) << usb_ep_pkg::F_TX_PEND)
			| (16'(tx_cnt_r[e] != '0) << usb_ep_pkg::F_TX_NOT_EMPTY);
		wire [15:0] role_mask = host_role_in ? (e == 0 ? usb_ep_pkg::HOST_EP0_MASK : usb_ep_pkg::HOST_MASK)
			: (e == 0 ? usb_ep_pkg::DEV_EP0_MASK : usb_ep_pkg::DEV_MASK);
		wire rdy_clr = (clr_hit && status_clr_mask_in[usb_ep_pkg::F_PKT_READY])
			|| (rd_autoclr_r && rd_ep_r == EW'(e));

		assign tx_pend_nxt[e] = send_go || auto_go || (tx_pend_r[e] && !done_hit);
		assign tx_cnt_nxt[e] = done_hit ? '0 : tx_cnt_r[e] + (PTR_W+1)'(wr_take);
		assign tx_type_nxt[e] = send_go ? send_type_in : auto_go ? (host_role_in ?
			usb_ep_pkg::trans_type_host_out : usb_ep_pkg::trans_type_device_in) : tx_type_r[e];
		assign tog_tx_nxt[e] = (tog_hit && dir_tx(tog_dir_in)) ? 1'b0 : tog_tx_r[e] ^ done_hit;
		assign tog_rx_nxt[e] = (tog_hit && dir_rx(tog_dir_in)) ? 1'b0 : tog_rx_r[e] ^ rx_take;
		assign rx_rdy_nxt[e] = rx_take || (rx_rdy_r[e] && !rdy_clr);
		assign rx_len_nxt[e] = rx_take ? rx_wcnt_r : rx_len_r[e];
		// the hardware set beats a clear in the same cycle
		assign sticky_nxt[e] = (sticky_r[e] & ~(clr_hit ? status_clr_mask_in : 16'h0000)) | evt_set | own_set;
		assign stat_w[e] = (sticky_r[e] | live) & role_mask;
		assign dma_rx_en_nxt[e] = (dma_hit && dir_rx(dma_dir_in)) ? dma_en_in : dma_rx_en_out[e];
		assign dma_tx_en_nxt[e] = (dma_hit && dir_tx(dma_dir_in)) ? dma_en_in : dma_tx_en_out[e];
		assign dma_rx_mode_nxt[e] = (dma_hit && dma_en_in && dir_rx(dma_dir_in)) ? dma_mode_in : dma_rx_mode_out[e];
		assign dma_tx_mode_nxt[e] = (dma_hit && dma_en_in && dir_tx(dma_dir_in)) ? dma_mode_in : dma_tx_mode_out[e];
		// with dma off the endpoint events reach the processor
		assign ep_irq_out[e] = (((|sticky_r[e][7:0]) || rx_rdy_r[e]) && !dma_rx_en_out[e])
			|| ((|sticky_r[e][15:8]) && !dma_tx_en_out[e]);
	end

	// ----------------------------------------------------------------
	// dma channel map
	// ----------------------------------------------------------------
	for (genvar c = 0; c < CH; c++) begin : g_ch
		wire map_hit = dma_map_in && (dma_map_ch_in == 3'(c)) && (dma_map_ep_in != '0);
		wire [EW-1:0] ep = ch_ep_r[c];
		always_ff @(posedge clk_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				ch_ep_r[c] <= '0;
				ch_ok_r[c] <= 1'b0;
			end else if (map_hit) begin
				ch_ep_r[c] <= dma_map_ep_in;
				ch_ok_r[c] <= 1'b1;
			end
		end
		assign dma_ch_ep_out[c*EW +: EW] = ep;
		// receive channels follow received packets, transmit channels free space
		if (c < usb_ep_pkg::DMA_RX_CH) begin : g_rx
			assign dma_req_out[c] = ch_ok_r[c] && dma_rx_en_out[ep] && rx_rdy_r[ep];
		end else begin : g_tx
			assign dma_req_out[c] = ch_ok_r[c] && dma_tx_en_out[ep] && !tx_pend_r[ep] && (tx_cnt_r[ep] < DEPTH);
		end
	end
	assign dma_ch_valid_out = ch_ok_r;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tx_pend_r <= '0;
			rx_rdy_r <= '0;
			tog_tx_r <= '0;
			tog_rx_r <= '0;
			dma_rx_en_out <= '0;
			dma_tx_en_out <= '0;
			dma_rx_mode_out <= '0;
			dma_tx_mode_out <= '0;
			tx_cnt_r <= '{default: '0};
			rx_len_r <= '{default: '0};
			tx_type_r <= '{default: '0};
			sticky_r <= '{default: '0};
		end else begin
			tx_pend_r <= tx_pend_nxt;
			rx_rdy_r <= rx_rdy_nxt;
			tog_tx_r <= tog_tx_nxt;
			tog_rx_r <= tog_rx_nxt;
			dma_rx_en_out <= dma_rx_en_nxt;
			dma_tx_en_out <= dma_tx_en_nxt;
			dma_rx_mode_out <= dma_rx_mode_nxt;
			dma_tx_mode_out <= dma_tx_mode_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			rx_len_r <= rx_len_nxt;
			tx_type_r <= tx_type_nxt;
			sticky_r <= sticky_nxt;
		end
	end

	wire [31:0] fifo_addr_nxt = usb_ep_pkg::FIFO_ADDR_BASE + usb_ep_pkg::FIFO_ADDR_STRIDE * 32'(status_ep_in);

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			status_out <= 16'h0000;
			fifo_addr_out <= 32'h0000_0000;
			rx_wcnt_r <= '0;
			tx_rptr_r <= '0;
		end else begin
			status_out <= stat_w[status_ep_in];
			fifo_addr_out <= fifo_addr_nxt;
			rx_wcnt_r <= link_rx_end_in ? '0 : rx_wcnt_r + (PTR_W+1)'(rx_we);
			tx_rptr_r <= link_tx_done_in ? '0 : tx_rptr_r + (PTR_W+1)'(link_tx_rd_in);
		end
	end

	// ----------------------------------------------------------------
	// receive readout
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_state_r <= RD_IDLE;
			rd_ep_r <= '0;
			rd_ptr_r <= '0;
			rd_len_r <= '0;
			rd_valid_out <= 1'b0;
			rd_done_out <= 1'b0;
			rd_ok_out <= 1'b0;
			rd_count_out <= '0;
			rd_autoclr_r <= 1'b0;
		end else begin
			rd_valid_out <= rd_issue;
			rd_done_out <= 1'b0;
			rd_autoclr_r <= 1'b0;
			case (rd_state_r)
				RD_IDLE: begin
					rd_ep_r <= rd_ep_in;
					rd_ptr_r <= '0;
					rd_len_r <= rx_len_r[rd_ep_in];
					if (rd_start && !rx_rdy_r[rd_ep_in]) begin
						rd_done_out <= 1'b1;
						rd_ok_out <= 1'b0;
						rd_count_out <= '0;
					end else if (rd_start) begin
						rd_state_r <= RD_RUN;
					end
				end
				RD_RUN: begin
					rd_ptr_r <= rd_ptr_r + (PTR_W+1)'(rd_issue);
					if (rd_finish) begin
						rd_done_out <= 1'b1;
						rd_ok_out <= 1'b1;
						rd_count_out <= rd_len_r;
						rd_autoclr_r <= auto_clear_packet_ready_in[rd_ep_r];
						rd_state_r <= RD_IDLE;
					end
				end
				default: begin
					rd_state_r <= RD_IDLE;
				end
			endcase
		end
	end

	ep_byte_ram #(.AW(EW + PTR_W)) u_rx_ram (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.wr_en_in(rx_we),
		.wr_addr_in({link_rx_ep_in, rx_wcnt_r[PTR_W-1:0]}),
		.wr_data_in(link_rx_data_in),
		.rd_addr_in({rd_ep_r, rd_ptr_r[PTR_W-1:0]}),
		.rd_data_out(rx_rd_data)
	);

	ep_byte_ram #(.AW(EW + PTR_W)) u_tx_ram (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.wr_en_in(tx_we),
		.wr_addr_in({wr_ep_in, tx_cnt_r[wr_ep_in][PTR_W-1:0]}),
		.wr_data_in(wr_data_in),
		.rd_addr_in({link_tx_ep_in, tx_rptr_r[PTR_W-1:0]}),
		.rd_data_out(tx_rd_data)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			val_cnt_r <= '0;
		end else begin
			val_cnt_r <= rd_done_out ? '0 : val_cnt_r + (PTR_W+1)'(rd_valid_out);
		end
	end

	read_count_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		rd_done_out && rd_ok_out |-> rd_count_out == val_cnt_r) else $error("read count mismatch");
	read_fail_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		rd_start && !rx_rdy_r[rd_ep_in] |=> rd_done_out && !rd_ok_out && !rd_valid_out)
		else $error("empty read not failed");
	read_done_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		rd_start && rx_rdy_r[rd_ep_in] && rx_len_r[rd_ep_in] == '0 |=> ##1 rd_done_out && rd_ok_out)
		else $error("zero length read not done");
	load_refuse_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		wr_valid_in && tx_pend_r[wr_ep_in] |-> wr_busy_out && !tx_we) else $error("load not refused");
	send_refuse_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		send_req_in && tx_pend_r[send_ep_in] |=> tx_type_r[$past(send_ep_in)] == $past(tx_type_r[send_ep_in]))
		else $error("busy trigger changed type");
	toggle_clear_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		tog_ok && dir_tx(tog_dir_in) |=> !tog_tx_r[$past(tog_ep_in)]) else $error("toggle not cleared");
	rx_toggle_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		link_rx_end_in && link_rx_good_in && !rx_rdy_r[link_rx_ep_in] && !tog_clr_in
		|=> tog_rx_r[$past(link_rx_ep_in)] != $past(tog_rx_r[link_rx_ep_in])) else $error("toggle not flipped");
	map_ep0_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		dma_map_in && dma_map_ep_in == '0 |=> $stable(dma_ch_valid_out) && $stable(dma_ch_ep_out))
		else $error("endpoint zero mapped");
	auto_send_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		tx_we && auto_transmit_on_full_packet_in[wr_ep_in] && tx_cnt_r[wr_ep_in] == PKT_LAST
		|=> link_tx_pend_out[$past(wr_ep_in)]) else $error("full packet not sent");
endmodule
`default_nettype wire

// ### tb/usb_link_partner.sv
// bus-side partner that sends packets to the block and acknowledges its transmissions
`timescale 1ns/1ps
`default_nettype none
module usb_link_partner (
	input wire logic clk_in,
	output logic rx_valid_out,
	output logic [1:0] rx_ep_out,
	output logic [7:0] rx_data_out,
	output logic rx_end_out,
	output logic rx_good_out,
	output logic tx_done_out,
	output logic tx_ack_out,
	output logic [1:0] tx_ep_out
);
	initial begin
		{rx_valid_out, rx_end_out, rx_good_out, tx_done_out, tx_ack_out} = '0;
		rx_ep_out = 2'h0;
		rx_data_out = 8'h5A;
		tx_ep_out = 2'h1;
	end
	task automatic send_pkt(input logic [1:0] ep, input logic [7:0] d[$]);
		foreach (d[i]) begin
			@(posedge clk_in);
			rx_valid_out <= 1'b1;
			rx_ep_out <= ep;
			rx_data_out <= d[i];
		end
		@(posedge clk_in);
		rx_valid_out <= 1'b0;
		rx_ep_out <= ep;
		{rx_end_out, rx_good_out} <= 2'h3;
		// released data line shows the inverse, so a stale byte never looks valid
		rx_data_out <= ~rx_data_out;
		@(posedge clk_in);
		{rx_end_out, rx_good_out} <= 2'h0;
	endtask
	task automatic ack(input logic [1:0] ep);
		@(posedge clk_in);
		tx_ep_out <= ep;
		{tx_done_out, tx_ack_out} <= 2'h3;
		@(posedge clk_in);
		{tx_done_out, tx_ack_out} <= 2'h0;
	endtask
endmodule
`default_nettype wire

// ### tb/tb_usb_endpoint_fifo_datapath.sv
// self-checking bench for the endpoint fifo data path
`timescale 1ns/1ps
`default_nettype none
module tb_usb_endpoint_fifo_datapath;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic host_role_in, rd_req_in, wr_valid_in, send_req_in, tog_clr_in, dma_map_in, dma_en_in, dma_dis_in;
	logic dma_mode_in, status_clr_in, link_rx_valid_in, link_rx_end_in, link_rx_good_in, link_tx_rd_in;
	logic link_in_token_in, link_tx_done_in, link_tx_ack_in, rd_valid_out, rd_done_out, rd_ok_out;
	logic wr_busy_out, send_ok_out, send_fail_out, link_rx_toggle_out, link_tx_toggle_out;
	logic [3:0] auto_transmit_on_full_packet_in, auto_clear_packet_ready_in, dma_rx_en_out, dma_tx_en_out;
	logic [3:0] dma_rx_mode_out, dma_tx_mode_out, ep_irq_out, link_tx_pend_out;
	logic [1:0] rd_ep_in, wr_ep_in, send_ep_in, tog_ep_in, dma_map_ep_in, dma_ep_in, status_ep_in;
	logic [1:0] link_rx_ep_in, link_tx_ep_in, link_evt_ep_in;
	logic [2:0] send_type_in, tog_dir_in, dma_map_ch_in, dma_dir_in, link_tx_type_out;
	logic [7:0] rd_data_out, wr_data_in, link_rx_data_in, link_tx_data_out;
	logic [6:0] rd_count_out, link_tx_len_out;
	logic [15:0] status_out, status_clr_mask_in, link_evt_in;
	logic [31:0] fifo_addr_out;
	logic [11:0] dma_ch_ep_out;
	logic [5:0] dma_ch_valid_out, dma_req_out;
	logic [15:0] exp_q[$], done_q[$], wr_q[$], send_q[$];
	logic [7:0] d[$];
	int mismatches = 0;
	int total_checks = 0;
	always #20 clk_in = ~clk_in;
	usb_endpoint_fifo_datapath dut_u (.*);
	usb_link_partner p_u (.clk_in(clk_in), .rx_valid_out(link_rx_valid_in), .rx_ep_out(link_rx_ep_in),
		.rx_data_out(link_rx_data_in), .rx_end_out(link_rx_end_in), .rx_good_out(link_rx_good_in),
		.tx_done_out(link_tx_done_in), .tx_ack_out(link_tx_ack_in), .tx_ep_out(link_tx_ep_in));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// result watcher: each result takes the oldest note of its kind
	// ----------------------------------------------------------------
	always @(posedge clk_in) begin
		if (rd_valid_out) chk(rd_data_out, exp_q.size() ? exp_q.pop_front() : 'x);
		if (rd_done_out) chk({rd_ok_out, rd_count_out}, done_q.size() ? done_q.pop_front() : 'x);
		if (wr_valid_in) chk(wr_busy_out, wr_q.size() ? wr_q.pop_front() : 'x);
		if (send_req_in) chk({send_ok_out, send_fail_out}, send_q.size() ? send_q.pop_front() : 'x);
	end
	task automatic rd(input logic [1:0] ep, input logic [15:0] res);
		done_q.push_back(res);
		@(posedge clk_in);
		rd_req_in <= 1'b1;
		rd_ep_in <= ep;
		@(posedge clk_in);
		rd_req_in <= 1'b0;
		for (int i = 0; i < 300 && rd_done_out !== 1'b1; i++) @(negedge clk_in);
		if (rd_done_out !== 1'b1) begin
			mismatches++;
			wrap_up();
		end
	endtask
	// loads never exceed the endpoint fifo size
	task automatic ld(input int n, input logic busy);
		repeat (n) begin
			@(posedge clk_in);
			wr_valid_in <= 1'b1;
			wr_ep_in <= 2'h1;
			wr_data_in <= 8'($urandom);
			wr_q.push_back(16'(busy));
		end
		@(posedge clk_in);
		wr_valid_in <= 1'b0;
	endtask
	task automatic snd(input logic [2:0] t, input logic ok);
		send_q.push_back({14'h0, ok, !ok});
		@(posedge clk_in);
		send_req_in <= 1'b1;
		send_ep_in <= 2'h1;
		send_type_in <= t;
		@(posedge clk_in);
		send_req_in <= 1'b0;
	endtask
	// k: 0 map channel, 1 dma enable, 2 dma disable, 3 toggle clear
	task automatic ctl(input int k, input logic [1:0] ep, input logic [2:0] v, input logic m);
		@(posedge clk_in);
		{dma_map_in, dma_en_in, dma_dis_in, tog_clr_in} <= 4'h8 >> k;
		{dma_map_ch_in, tog_dir_in, dma_dir_in} <= {3{v}};
		{dma_map_ep_in, dma_ep_in, tog_ep_in} <= {3{ep}};
		dma_mode_in <= m;
		@(posedge clk_in);
		{dma_map_in, dma_en_in, dma_dis_in, tog_clr_in} <= 4'h0;
		@(negedge clk_in);
	endtask
	initial begin
		{host_role_in, rd_req_in, wr_valid_in, send_req_in, tog_clr_in, dma_map_in, dma_en_in, dma_dis_in} = '0;
		{dma_mode_in, status_clr_in, link_tx_rd_in, link_in_token_in, rd_ep_in, wr_ep_in, send_ep_in} = '0;
		{tog_ep_in, dma_map_ep_in, dma_ep_in, status_ep_in, link_evt_ep_in, send_type_in, tog_dir_in} = '0;
		{dma_map_ch_in, dma_dir_in, wr_data_in, status_clr_mask_in, link_evt_in} = '0;
		auto_transmit_on_full_packet_in = 4'h0;
		auto_clear_packet_ready_in = 4'hF;
		void'($urandom(32'h713E));
		repeat (2) @(posedge clk_in);
		rst_b_in <= 1'b1;
		rd(2'h1, 16'h0000);
		p_u.send_pkt(2'h1, d);
		rd(2'h1, 16'h0080);
		rd(2'h1, 16'h0000);
		repeat (3) d.push_back(8'($urandom));
		foreach (d[i]) exp_q.push_back(16'(d[i]));
		p_u.send_pkt(2'h2, d);
		rd(2'h2, 16'h0083);
		chk(link_rx_toggle_out, 1'b1);
		$display("receive test done");
		for (int t = 0; t < 5; t++) begin
			ld(2, 1'b0);
			@(negedge clk_in);
			chk(link_tx_pend_out[1], 1'b0);
			@(posedge clk_in);
			link_tx_rd_in <= 1'b1;
			@(posedge clk_in);
			link_tx_rd_in <= 1'b0;
			repeat (2) @(negedge clk_in);
			chk(link_tx_data_out, wr_data_in);
			snd(3'(t), 1'b1);
			snd(3'(t), 1'b0);
			ld(1, 1'b1);
			@(negedge clk_in);
			chk({link_tx_type_out, link_tx_len_out, link_tx_toggle_out}, {3'(t), 7'h02, 1'(t)});
			p_u.ack(2'h1);
		end
		@(negedge clk_in);
		chk({link_tx_pend_out[1], link_tx_toggle_out}, 2'h1);
		ctl(3, 2'h1, 3'h5, 1'b0);
		chk(link_tx_toggle_out, 1'b1);
		ctl(3, 2'h1, usb_ep_pkg::dir_device_in, 1'b0);
		chk(link_tx_toggle_out, 1'b0);
		@(posedge clk_in);
		auto_transmit_on_full_packet_in <= 4'h2;
		ld(64, 1'b0);
		@(negedge clk_in);
		chk({link_tx_pend_out[1], link_tx_len_out}, 8'hC0);
		chk(link_tx_type_out, usb_ep_pkg::trans_type_device_in);
		p_u.ack(2'h1);
		$display("transmit test done");
		@(posedge clk_in);
		{status_ep_in, link_evt_ep_in, link_evt_in} <= {2'h1, 2'h1, 16'h0008};
		@(posedge clk_in);
		link_evt_in <= 16'h0000;
		repeat (3) @(negedge clk_in);
		chk({status_out[3], ep_irq_out[1]}, 2'h3);
		@(posedge clk_in);
		{status_clr_in, status_clr_mask_in} <= {1'b1, status_out};
		@(posedge clk_in);
		status_clr_in <= 1'b0;
		repeat (2) @(negedge clk_in);
		chk(status_out[3], 1'b0);
		ctl(0, 2'h1, 3'h0, 1'b0);
		ctl(0, 2'h2, 3'h3, 1'b0);
		ctl(0, 2'h0, 3'h1, 1'b0);
		chk({dma_ch_valid_out, dma_ch_ep_out[7:6], dma_ch_ep_out[1:0]}, {6'h09, 2'h2, 2'h1});
		ctl(1, 2'h1, usb_ep_pkg::dir_device_out, 1'b1);
		ctl(1, 2'h2, usb_ep_pkg::dir_device_in, 1'b1);
		ctl(2, 2'h2, 3'h7, 1'b0);
		chk({dma_rx_en_out, dma_tx_en_out, dma_rx_mode_out, dma_tx_mode_out}, 16'h2424);
		chk(dma_req_out, 6'h08);
		ctl(2, 2'h2, usb_ep_pkg::dir_device_in, 1'b0);
		chk(dma_tx_en_out, 4'h0);
		for (int e = 0; e < 4; e++) begin
			@(posedge clk_in);
			status_ep_in <= 2'(e);
			repeat (2) @(negedge clk_in);
			chk(fifo_addr_out[15:0], 16'(usb_ep_pkg::FIFO_ADDR_BASE + usb_ep_pkg::FIFO_ADDR_STRIDE * e));
		end
		$display("status and dma test done");
		wrap_up();
	end
endmodule
`default_nettype wire
